/* File: common/smio_pkg.sv */
/*
  Package for the multi-width serial flash pin interface: transfer widths,
  pin bundles, received-byte bundle and shared constants.
  Assumes one system clock far faster than the serial clock on the pins.
*/
package smio_pkg;

  // ==========================================================
  // Constants
  // ==========================================================
  localparam int unsigned BYTE_W    = 8;     // Bits per transferred byte
  localparam int unsigned LINES_W   = 4;     // Data lines 0..3
  localparam int unsigned CNT_W     = 4;     // Bit counter width
  localparam logic [3:0]  CNT_ZERO  = 4'h0;  // Counter reset value
  localparam logic [3:0]  CNT_BYTE  = 4'h8;  // Bits in a full byte
  localparam logic [3:0]  OE_NONE   = 4'h0;  // All lines released
  localparam logic [3:0]  OE_SINGLE = 4'h2;  // Serial output line only
  localparam logic [7:0]  BYTE_ZERO = 8'h00; // Shift register reset value

  // ==========================================================
  // Types
  // ==========================================================
  // Bits moved per serial clock in a phase
  typedef enum logic [1:0] {
    SMIO_W1 = 2'b00,  // Single line
    SMIO_W2 = 2'b01,  // Lines 0-1
    SMIO_W4 = 2'b10   // Lines 0-3
  } smio_width_t;

  // Raw pin levels as seen at the device
  typedef struct packed {
    logic       sck;     // Serial clock from host
    logic       cs_n;    // Chip select, active low
    logic [3:0] io;      // data_line_3 .. data_line_0
  } smio_pins_t;

  // One received byte
  typedef struct packed {
    logic       valid;   // One-cycle strobe
    logic       first;   // Byte is the instruction
    logic [7:0] data;    // Byte value, first bit in bit 7
  } smio_rx_t;

endpackage

/* File: verilog/smio_device.sv */
/*
  Device-side pin logic of a multi-width serial flash interface: pin
  synchronisers, select and power state, hold, single/dual/quad receive
  and transmit shifting.
  Assumes sys_clk runs at least eight times the serial clock rate and
  that the command decoder behind it steers widths at byte boundaries.
*/
`timescale 1ns/10ps

// Behaviour
// (R1) Sample incoming bits on serial clock rise
// (R2) Change driven data only after clock fall
// (R3) Chip select high: ignore inputs, tristate
// (R4) Deselected and not busy means standby power
// (R5) Chip select low selects, active power
// (R6) No command before first chip select fall
// (R7) Single commands: in on line 0, out line 1
// (R8) Output commands: address single, data wide
// (R9) I/O commands: both directions same width
// (R10) Line 0 bidirectional in dual and quad
// (R11) Write-protect pin becomes line 2 in quad
// (R12) Hold pin becomes line 3 in quad
// (R13) Single protocol plus two/four-bit transfers
// (R14) Accept clock modes 0 and 3
// (R15) Instruction always one bit per clock
// (R16) Chip select low for whole command
// (R17) Hold: tristate output, ignore clock, input
// (R18) MSB first, higher line more significant
module smio_device
  import smio_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // Serial pins (three signals per data line)
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic [3:0]  io_in,
  output      logic [3:0]  io_out,
  output      logic [3:0]  io_oe,
  // Steering from the command logic
  input  wire logic        quad_en,
  input  wire smio_width_t rx_width,
  input  wire smio_width_t tx_width,
  input  wire logic        tx_active,
  input  wire logic [7:0]  tx_data,
  input  wire logic        busy,
  // Results towards the command logic
  output      smio_rx_t    rx,
  output      logic        tx_take,
  output      logic        selected,
  output      logic        standby,
  output      logic        wr_protect
);

  // ==========================================================
  // Functions
  // ==========================================================
  // Quad needs the two shared pins; fall back to dual without it
  function automatic smio_width_t eff_width(smio_width_t w, logic qe);
    if (w == SMIO_W4 && !qe)
      return SMIO_W2;
    return w;
  endfunction

  // Bits moved per clock for a width
  function automatic logic [3:0] width_bits(smio_width_t w);
    case (w)
      SMIO_W2: return 4'h2;
      SMIO_W4: return 4'h4;
      default: return 4'h1;
    endcase
  endfunction

  // Shift lines in, higher line more significant
  function automatic logic [7:0] shift_in(logic [7:0] sh, smio_width_t w,
                                          logic [3:0] l);
    case (w)
      SMIO_W2: return {sh[5:0], l[1], l[0]};     // R18
      SMIO_W4: return {sh[3:0], l};              // R18
      default: return {sh[6:0], l[0]};           // R7
    endcase
  endfunction

  // ==========================================================
  // Pin synchronisers and edge finding
  // ==========================================================
  smio_pins_t  sy1_q;        // First stage, read only by second
  smio_pins_t  sy2_q;        // Stable pin levels
  logic        sck3_q;       // Previous clock level
  logic        cs3_q;        // Previous select level
  logic        sck_rise;     // Serial clock rose
  logic        sck_fall;     // Serial clock fell
  logic        cs_fall;      // Select asserted
  logic        sel;          // Device selected now

  // Two flops on every pin before any logic looks at it
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      sy1_q  <= '{sck: 1'b0, cs_n: 1'b1, io: OE_NONE};
      sy2_q  <= '{sck: 1'b0, cs_n: 1'b1, io: OE_NONE};
      sck3_q <= 1'b0;
      cs3_q  <= 1'b1;
    end
    else
    begin
      sy1_q  <= '{sck: sck, cs_n: cs_n, io: io_in};
      sy2_q  <= sy1_q;
      sck3_q <= sy2_q.sck;
      cs3_q  <= sy2_q.cs_n;
    end
  end

  // Edges work for both idle levels of the clock
  assign sck_rise = sy2_q.sck & ~sck3_q;      // R14
  assign sck_fall = ~sy2_q.sck & sck3_q;      // R14
  assign cs_fall  = ~sy2_q.cs_n & cs3_q;
  assign sel      = ~sy2_q.cs_n;

  // ==========================================================
  // Select, power and protect state
  // ==========================================================
  logic        armed_q;      // Seen a select fall since reset
  logic [1:0]  warm_q;       // Pin levels have reached the second stage
  logic        cs_hi_q;      // Select pin seen high since reset
  logic        hold_q;       // Hold condition in force
  logic        xfer;         // Clock edges count
  logic        instr_done_q; // Instruction byte complete

  // Power-up lockout until the first select fall.
  // The sync stages reset to deselected, so a pin held low through reset
  // would look like a fall; only a fall after a real high level arms.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      warm_q  <= 2'b00;
      cs_hi_q <= 1'b0;
      armed_q <= 1'b0;
    end
    else
    begin
      warm_q <= {warm_q[0], 1'b1};
      // Trust the select level once it comes from the pin
      if (warm_q[1] && sy2_q.cs_n)
        cs_hi_q <= 1'b1;
      if (cs_fall && cs_hi_q)
        armed_q <= 1'b1;                      // R6
    end
  end

  // Hold starts and ends only while the clock is low; deselect ends it at any clock level
  always_ff @(posedge sys_clk)
  begin
    if (srst || !sel)
      hold_q <= 1'b0;
    else if (!sy2_q.sck)
      hold_q <= ~quad_en & ~sy2_q.io[3];      // R12 R17
  end

  // A command only runs while selected, armed and not paused
  assign xfer = sel & armed_q & ~hold_q;      // R3 R16 R17

  // Power state and protect level, all registered
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      selected   <= 1'b0;
      standby    <= 1'b1;
      wr_protect <= 1'b0;
    end
    else
    begin
      selected   <= sel;                      // R5
      standby    <= ~sel & ~busy;             // R4 R5
      wr_protect <= ~quad_en & ~sy2_q.io[2];  // R11
    end
  end

  // ==========================================================
  // Receive path
  // ==========================================================
  logic [7:0]  rx_sh_q;      // Partial byte
  logic [3:0]  rx_cnt_q;     // Bits held so far
  smio_width_t rx_w;         // Width of this clock
  logic [7:0]  rx_next;      // Byte after this clock
  logic [3:0]  rx_cnt_next;  // Count after this clock

  // Instruction stays single whatever the later phases ask for
  assign rx_w        = instr_done_q ? eff_width(rx_width, quad_en)
                                    : SMIO_W1;       // R15 R8 R9
  assign rx_next     = shift_in(rx_sh_q, rx_w, sy2_q.io);
  assign rx_cnt_next = rx_cnt_q + width_bits(rx_w);

  // Sample on rises only; a new select restarts framing
  always_ff @(posedge sys_clk)
  begin
    if (srst || !sel)
    begin
      rx_sh_q      <= BYTE_ZERO;
      rx_cnt_q     <= CNT_ZERO;
      instr_done_q <= 1'b0;
      rx           <= '0;
    end
    else
    begin
      rx.valid <= 1'b0;
      if (sck_rise && xfer)                          // R1 R13
      begin
        if (rx_cnt_next == CNT_BYTE)
        begin
          rx           <= '{valid: 1'b1, first: ~instr_done_q,
                            data: rx_next};
          rx_cnt_q     <= CNT_ZERO;
          instr_done_q <= 1'b1;
        end
        else
        begin
          rx_cnt_q <= rx_cnt_next;
        end
        rx_sh_q <= rx_next;
      end
    end
  end

  // ==========================================================
  // Transmit path
  // ==========================================================
  logic [7:0]  tx_sh_q;      // Bits still to send, top first
  logic [3:0]  tx_left_q;    // Count of bits still to send
  smio_width_t tx_w_q;       // Width of the bits on the lines
  smio_width_t tx_w;         // Width for this fall
  logic [7:0]  tx_byte;      // Byte feeding this fall

  assign tx_w    = eff_width(tx_width, quad_en);
  assign tx_byte = (tx_left_q == CNT_ZERO) ? tx_data : tx_sh_q;

  // Lines change only on falls so the host samples on the next rise;
  // at 8x oversampling the new bit lands about three cycles after it
  always_ff @(posedge sys_clk)
  begin
    if (srst || !sel || hold_q)
    begin
      io_oe     <= OE_NONE;                          // R3 R17
      tx_left_q <= srst || !sel ? CNT_ZERO : tx_left_q;
      tx_take   <= 1'b0;
      if (srst)
      begin
        io_out  <= OE_NONE;
        tx_sh_q <= BYTE_ZERO;
        tx_w_q  <= SMIO_W1;
      end
    end
    else
    begin
      tx_take <= 1'b0;
      if (sck_fall && xfer)                          // R2
      begin
        if (!tx_active)
        begin
          io_oe     <= OE_NONE;
          tx_left_q <= CNT_ZERO;
        end
        else
        begin
          tx_take   <= (tx_left_q == CNT_ZERO);
          tx_w_q    <= tx_w;
          tx_left_q <= (tx_left_q == CNT_ZERO ? CNT_BYTE : tx_left_q)
                       - width_bits(tx_w);
          case (tx_w)
            SMIO_W2:
            begin
              io_out  <= {2'b00, tx_byte[7:6]};      // R10 R18
              io_oe   <= 4'h3;
              tx_sh_q <= {tx_byte[5:0], 2'b00};
            end
            SMIO_W4:
            begin
              io_out  <= tx_byte[7:4];               // R11 R12 R18
              io_oe   <= 4'hf;
              tx_sh_q <= {tx_byte[3:0], 4'h0};
            end
            default:
            begin
              io_out  <= {2'b00, tx_byte[7], 1'b0};  // R7
              io_oe   <= OE_SINGLE;
              tx_sh_q <= {tx_byte[6:0], 1'b0};
            end
          endcase
        end
      end
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  // Deselect releases every line by the next cycle
  a_cs_high_float: assert property ( // R3
    @(posedge sys_clk) disable iff (srst)
    sy2_q.cs_n |=> (io_oe == OE_NONE))
    else $error("lines driven while deselected");

  // Driven data moves only right after a detected fall
  a_out_after_fall: assert property ( // R2
    @(posedge sys_clk) disable iff (srst)
    ($changed(io_out) && sel) |-> $past(sck_fall))
    else $error("output changed without clock fall");

  // A byte completes only on a rising clock edge
  a_rx_on_rise: assert property ( // R1
    @(posedge sys_clk) disable iff (srst)
    rx.valid |-> $past(sck_rise) && $past(xfer))
    else $error("byte completed without clock rise");

  // No byte before the first select fall
  a_armed_first: assert property ( // R6
    @(posedge sys_clk) disable iff (srst)
    rx.valid |-> $past(armed_q))
    else $error("byte taken before first select fall");

  // Idle and not busy gives standby a cycle later
  a_standby_idle: assert property ( // R4
    @(posedge sys_clk) disable iff (srst)
    (sy2_q.cs_n && !busy) |=> standby)
    else $error("standby missing while idle");

  // Selection forces the active state
  a_active_sel: assert property ( // R5
    @(posedge sys_clk) disable iff (srst)
    sel |=> !standby && selected)
    else $error("not active while selected");

  // Instruction clocks add exactly one bit
  a_instr_single: assert property ( // R15
    @(posedge sys_clk) disable iff (srst)
    (sck_rise && xfer && !instr_done_q && rx_cnt_q != 4'h7)
      |=> (rx_cnt_q == $past(rx_cnt_q) + 4'h1))
    else $error("instruction bit not single width");

  // Hold releases the lines a cycle later
  a_hold_float: assert property ( // R17
    @(posedge sys_clk) disable iff (srst)
    hold_q |=> (io_oe == OE_NONE))
    else $error("lines driven during hold");

  // Lines 2 and 3 drive only in quad
  a_quad_lines: assert property ( // R11
    @(posedge sys_clk) disable iff (srst)
    (io_oe[3:2] != 2'b00) |-> $past(quad_en))
    else $error("shared pins driven outside quad");

  // Single width drives the serial output line only
  a_single_so: assert property ( // R7
    @(posedge sys_clk) disable iff (srst)
    (io_oe != OE_NONE && tx_w_q == SMIO_W1) |-> (io_oe == OE_SINGLE))
    else $error("single width drove wrong line");

  c_dual_out: cover property (
    @(posedge sys_clk) disable iff (srst)
    tx_take && tx_w_q == SMIO_W2);
  c_quad_in: cover property (
    @(posedge sys_clk) disable iff (srst)
    rx.valid && !rx.first && rx_w == SMIO_W4);
  c_hold: cover property (
    @(posedge sys_clk) disable iff (srst) $rose(hold_q));
  c_mode3: cover property (
    @(posedge sys_clk) disable iff (srst) cs_fall && sy2_q.sck);

endmodule

/* File: dv/smio_host.sv */
/*
  Host-side serial master model driving the flash pins.
  Assumes the bench calls its tasks; lines 2 and 3 are pulled up.
*/
`timescale 1ns/10ps
module smio_host
  import smio_pkg::*;
(
  // Clock for the floating-line pattern
  input  wire logic       sys_clk,
  // Device side of the pins
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe,
  // Host-driven pins
  output      logic       sck,
  output      logic       cs_n,
  output      logic [3:0] io_in
);
  // ==========================================
  // Pin state
  // ==========================================
  logic [3:0] h_oe;     // Host drives line
  logic [3:0] h_val;    // Host line level
  logic       tog = 1'b0; // Released lines 0-1 wander
  logic       mode3;    // Clock idles high
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b0;        // Low through reset: no fall yet
    h_oe = 4'h0;
    h_val = 4'h0;
    mode3 = 1'b0;
  end
  always @(posedge sys_clk)
    tog <= ~tog;
  // Wire level: device, host, then pull-up or noise
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      io_in[i] = io_oe[i] ? io_out[i] : h_oe[i] ? h_val[i] :
                 (i > 1) ? 1'b1 : tog;
  end
  // ==========================================
  // Framing
  // ==========================================
  task automatic begin_cmd(input logic m3);
    mode3 = m3;
    sck = m3;           // Mode 0 or mode 3 idle level
    #400 cs_n = 1'b0;
    #400;
  endtask
  task automatic end_cmd;
    #400 sck = mode3;
    #400 cs_n = 1'b1;
    h_oe = 4'h0;
    #400;
  endtask
  // n groups; drive d msb first when drv, sample late into q
  // Sampling just before the next fall avoids a marginal setup.
  task automatic xfer(input smio_width_t w, input logic drv,
                      input logic [7:0] d, input int n,
                      output logic [7:0] q);
    int         b;
    logic [3:0] m;
    b = (w == SMIO_W1) ? 1 : (w == SMIO_W2) ? 2 : 4;
    m = 4'((1 << b) - 1);
    q = 8'h00;
    for (int k = 0; k < n; k++)
    begin
      sck = 1'b0;
      h_oe = (h_oe & ~m) | (drv ? m : 4'h0);
      h_val = (h_val & ~m) | (4'(d >> (8 - b * (k + 1))) & m);
      #400 sck = 1'b1;
      #400;
      q = 8'(q << b) | ((b == 1) ? 8'(io_in[1]) : 8'(io_in & m));
    end
  endtask
endmodule

/* File: dv/smio_device_test.sv */
/*
  Self-checking bench for the device pin logic with a host model.
  Assumes the design answers within a few system clocks of a pin edge.
*/
`timescale 1ns/10ps
module smio_device_test;
  import smio_pkg::*;
  // ==========================================
  // Signals
  // ==========================================
  logic        sys_clk;
  logic        srst;
  logic        sck;
  logic        cs_n;
  logic [3:0]  io_in;
  logic [3:0]  io_out;
  logic [3:0]  io_oe;
  logic        quad_en;
  smio_width_t rx_width;
  smio_width_t tx_width;
  logic        tx_active;
  logic [7:0]  tx_data;
  logic        busy;
  smio_rx_t    rx;
  logic        tx_take;
  logic        selected;
  logic        standby;
  logic        wr_protect;
  int          n_errors = 0;   // Mismatches
  int          tests_run = 0;  // Comparisons
  int          n_rx = 0;       // Received byte strobes
  int          n_take = 0;     // Transmit byte takes
  int          cyc = 0;        // Timeout counter
  logic [7:0]  d;
  logic [7:0]  d2;
  logic [7:0]  t;
  logic [7:0]  q;
  int          n0;
  int          k0;
  smio_width_t w;
  smio_device dut_u (.sys_clk(sys_clk), .srst(srst), .sck(sck),
    .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
    .quad_en(quad_en), .rx_width(rx_width), .tx_width(tx_width),
    .tx_active(tx_active), .tx_data(tx_data), .busy(busy), .rx(rx),
    .tx_take(tx_take), .selected(selected), .standby(standby),
    .wr_protect(wr_protect));
  smio_host host_u (.sys_clk(sys_clk), .io_out(io_out),
    .io_oe(io_oe), .sck(sck), .cs_n(cs_n), .io_in(io_in));
  // ==========================================
  // Clock, monitors, timeout
  // ==========================================
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Count strobes; a lost or doubled pulse shows in the totals
  always @(posedge sys_clk)
  begin
    if (rx.valid === 1'b1) n_rx++;
    if (tx_take === 1'b1) n_take++;
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      test_done();
    end
  end
  // ==========================================
  // Helpers
  // ==========================================
  task automatic sync(input int n);
    repeat (n) @(posedge sys_clk);
    #5;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Enabled lines for a returning width
  function automatic logic [3:0] lanes(input smio_width_t x);
    return (x == SMIO_W1) ? OE_SINGLE : (x == SMIO_W2) ? 4'h3 : 4'hf;
  endfunction
  task automatic test_done;
    $display("Checks %0d, errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==========================================
  // Main sequence
  // ==========================================
  initial
  begin
    void'($urandom(78));
    srst = 1'b1;
    quad_en = 1'b0;
    rx_width = SMIO_W1;
    tx_width = SMIO_W1;
    tx_active = 1'b0;
    tx_data = 8'h00;
    busy = 1'b0;
    sync(3);
    srst = 1'b0;
    sync(2);
    check(standby, 8'h1);
    check(io_oe, 8'h0);
    // Byte with no select fall since reset is ignored
    host_u.xfer(SMIO_W1, 1'b1, 8'ha5, 8, q);
    sync(6);
    check(8'(n_rx), 8'h0);
    host_u.end_cmd();
    // Every width in both clock modes
    for (int i = 0; i < 6; i++)
    begin
      w = smio_width_t'(i % 3);
      quad_en = (w == SMIO_W4);
      busy = 1'($urandom);
      d = 8'($urandom);
      d2 = 8'($urandom);
      t = 8'($urandom);
      n0 = n_rx;
      host_u.begin_cmd(1'(i / 3));
      sync(4);
      check(selected, 8'h1);
      check(standby, 8'h0);
      host_u.xfer(SMIO_W1, 1'b1, d, 8, q);
      sync(6);
      check(rx.data, d);
      check(rx.first, 8'h1);
      rx_width = w;
      host_u.xfer(w, 1'b1, d2, 8 >> i % 3, q);
      sync(6);
      check(8'(n_rx - n0), 8'h2);
      check(rx.data, d2);
      check(rx.first, 8'h0);
      tx_width = w;
      tx_data = t;
      tx_active = 1'b1;
      k0 = n_take;
      host_u.xfer(w, 1'b0, 8'h00, 8 >> i % 3, q);
      check(q, t);
      check(io_oe, lanes(w));
      check(8'(n_take - k0), 8'h1);
      tx_active = 1'b0;
      host_u.end_cmd();
      sync(6);
      check(io_oe, 8'h0);
      check(selected, 8'h0);
      check(standby, 8'(!busy));
    end
    // Pause between bytes: clocks during it must be ignored
    quad_en = 1'b0;
    rx_width = SMIO_W1;
    n0 = n_rx;
    host_u.begin_cmd(1'b0);
    host_u.xfer(SMIO_W1, 1'b1, d, 8, q);
    host_u.sck = 1'b0;
    #400 host_u.h_oe[3] = 1'b1;
    host_u.h_val[3] = 1'b0;
    #400 host_u.xfer(SMIO_W1, 1'b1, 8'hff, 4, q);
    host_u.sck = 1'b0;
    #400 host_u.h_oe[3] = 1'b0;
    #400 host_u.xfer(SMIO_W1, 1'b1, d2, 8, q);
    sync(6);
    check(8'(n_rx - n0), 8'h2);
    check(rx.data, d2);
    host_u.end_cmd();
    // Write-protect only outside quad
    host_u.h_oe[2] = 1'b1;
    host_u.h_val[2] = 1'b0;
    sync(6);
    check(wr_protect, 8'h1);
    quad_en = 1'b1;
    sync(6);
    check(wr_protect, 8'h0);
    host_u.h_oe[2] = 1'b0;
    test_done();
  end
endmodule
